// >>> design/ucp_device.sv
// ucp_device: cell port configuration registers, rx interrupt logic and idle cell source
`timescale 1ns/10ps
module ucp_device
  import ucp_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // register link
  ucp_link_if.device      link,
  // mode and events
  input  wire logic       atmMode,
  input  wire logic       rxOverrunEvt,
  input  wire logic       rxUnderrunEvt,
  input  wire logic       rxShortCellEvt,
  // tx cell stream
  input  wire logic       userCellAvail,
  input  wire logic       octetReq,
  output logic [7:0]      txOctet,
  output logic            txOctetIsIdle,
  // configuration seen by the port
  output logic            cellHandshake,
  output logic            multiPortSelect,
  output logic            wideBusSelect,
  output logic [5:0]      cellLength,
  output logic [4:0]      txFifoDepth,
  output logic            rxQueueClear
);
  import ucp_pkg::*;

  typedef enum logic [1:0] {IDLE_OFF, IDLE_HDR, IDLE_PAY} ucp_idle_e;

  ////////////////////////////////////////////////////////////////////////////
  // link clock sampling: strobes are held by the host across a full link edge
  logic [SYNC_STAGES-1:0] clkSync_r;
  logic                   edgeSeen_r;
  logic [7:0]             hdr_r [5];
  logic [7:0]             pay_r;
  logic [7:0]             cfg_r;
  logic [5:3]             irqEn_r;
  logic                   qReset_r;
  logic                   ovrFlag_r;
  logic                   undFlag_r;
  logic                   runtFlag_r;
  logic                   wrDo;
  logic                   rdDo;

  always_ff @(posedge core_clk)
  begin
    if (rst) clkSync_r <= '0;
    else     clkSync_r <= {clkSync_r[SYNC_STAGES-2:0], link.linkClk};
  end

  // a rising link edge counts once stages two and three agree high after low
  always_ff @(posedge core_clk)
  begin
    if (rst) edgeSeen_r <= 1'b0;
    else     edgeSeen_r <= clkSync_r[1] & clkSync_r[2];
  end
  assign wrDo = link.wrStb & clkSync_r[1] & clkSync_r[2] & ~edgeSeen_r;
  assign rdDo = link.rdStb & clkSync_r[1] & clkSync_r[2] & ~edgeSeen_r;

  ////////////////////////////////////////////////////////////////////////////
  // writable registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hdr_r[0] <= RST_IDLE_HDR1;
      hdr_r[1] <= RST_IDLE_HDR2;
      hdr_r[2] <= RST_IDLE_HDR3;
      hdr_r[3] <= RST_IDLE_HDR4;
      hdr_r[4] <= RST_IDLE_HDR5;
      pay_r    <= RST_IDLE_PAY;
      cfg_r    <= RST_PORT_CFG;
      irqEn_r  <= 3'b000;
      qReset_r <= 1'b0;
    end
    else if (wrDo)
    begin
      if (link.addr == ADDR_IDLE_HDR1) hdr_r[0] <= link.wrData;
      else if (link.addr == ADDR_IDLE_HDR2) hdr_r[1] <= link.wrData;
      else if (link.addr == ADDR_IDLE_HDR3) hdr_r[2] <= link.wrData;
      else if (link.addr == ADDR_IDLE_HDR4) hdr_r[3] <= link.wrData;
      else if (link.addr == ADDR_IDLE_HDR5) hdr_r[4] <= link.wrData;
      else if (link.addr == ADDR_IDLE_PAY) pay_r <= link.wrData;
      else if (link.addr == ADDR_PORT_CFG) cfg_r <= {2'b00, link.wrData[5:0]};
      else if (link.addr == ADDR_RX_IRQ)
      begin
        // underrun enable is read-only and stays zero
        irqEn_r  <= {link.wrData[IRQ_OVR_EN], 1'b0, link.wrData[IRQ_RUNT_EN]};
        qReset_r <= link.wrData[IRQ_QRESET];
      end
    end
  end

  // one-cycle clear on a 0-to-1 write of the queue reset bit, in ATM mode only
  always_ff @(posedge core_clk)
  begin
    if (rst) rxQueueClear <= 1'b0;
    else     rxQueueClear <= wrDo & (link.addr == ADDR_RX_IRQ) & link.wrData[IRQ_QRESET]
                             & ~qReset_r & atmMode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags: a new event wins over the read that clears
  logic rdIrq;
  assign rdIrq = rdDo & (link.addr == ADDR_RX_IRQ);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ovrFlag_r  <= 1'b0;
      undFlag_r  <= 1'b0;
      runtFlag_r <= 1'b0;
    end
    else
    begin
      ovrFlag_r  <= (atmMode & rxOverrunEvt)   | (ovrFlag_r  & ~rdIrq);
      undFlag_r  <= (atmMode & rxUnderrunEvt)  | (undFlag_r  & ~rdIrq);
      runtFlag_r <= (atmMode & rxShortCellEvt) | (runtFlag_r & ~rdIrq);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst) link.irqReq <= 1'b0;
    else     link.irqReq <= atmMode & ((ovrFlag_r & irqEn_r[5]) | (undFlag_r & irqEn_r[4])
                                     | (runtFlag_r & irqEn_r[3]));
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port
  logic [7:0] rdMux;
  always_comb
  begin
    rdMux = 8'h00;
    if (link.addr == ADDR_IDLE_HDR1) rdMux = hdr_r[0];
    else if (link.addr == ADDR_IDLE_HDR2) rdMux = hdr_r[1];
    else if (link.addr == ADDR_IDLE_HDR3) rdMux = hdr_r[2];
    else if (link.addr == ADDR_IDLE_HDR4) rdMux = hdr_r[3];
    else if (link.addr == ADDR_IDLE_HDR5) rdMux = hdr_r[4];
    else if (link.addr == ADDR_IDLE_PAY) rdMux = pay_r;
    else if (link.addr == ADDR_PORT_CFG) rdMux = cfg_r;
    else if (link.addr == ADDR_RX_IRQ)
      rdMux = {1'b0, qReset_r, irqEn_r, ovrFlag_r, undFlag_r, runtFlag_r};
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      link.rdData  <= 8'h00;
      link.rdValid <= 1'b0;
    end
    else
    begin
      link.rdValid <= rdDo;
      if (rdDo) link.rdData <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode; held at defaults outside ATM mode
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cellHandshake   <= 1'b0;
      multiPortSelect <= 1'b1;
      wideBusSelect   <= 1'b0;
      cellLength      <= CELL_LEN_NORMAL;
      txFifoDepth     <= DEPTH_CODE0;
    end
    else
    begin
      cellHandshake   <= atmMode & ~cfg_r[CFG_MULTI] & cfg_r[CFG_HANDSHAKE];
      multiPortSelect <= atmMode ? cfg_r[CFG_MULTI] : 1'b1;
      wideBusSelect   <= atmMode & cfg_r[CFG_WIDE];
      if (atmMode & cfg_r[CFG_SHORT]) cellLength <= CELL_LEN_SHORT;
      else if (atmMode & cfg_r[CFG_WIDE]) cellLength <= CELL_LEN_WIDE;
      else cellLength <= CELL_LEN_NORMAL;
      case (atmMode ? cfg_r[CFG_DEPTH_HI:CFG_DEPTH_LO] : 2'b00)
        2'b00:   txFifoDepth <= DEPTH_CODE0;
        2'b01:   txFifoDepth <= DEPTH_CODE1;
        2'b10:   txFifoDepth <= DEPTH_CODE2;
        default: txFifoDepth <= DEPTH_CODE3;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle cell source; a cell once started runs to its end
  ucp_idle_e  idleSt_r;
  logic [5:0] octCnt_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      idleSt_r      <= IDLE_OFF;
      octCnt_r      <= 6'd0;
      txOctet       <= 8'h00;
      txOctetIsIdle <= 1'b0;
    end
    else
    begin
      txOctetIsIdle <= 1'b0;
      case (idleSt_r)
        IDLE_OFF:
          if (octetReq & atmMode & ~userCellAvail)
          begin
            txOctet       <= hdr_r[0];
            txOctetIsIdle <= 1'b1;
            octCnt_r      <= 6'd1;
            idleSt_r      <= IDLE_HDR;
          end
        IDLE_HDR:
          if (octetReq)
          begin
            txOctetIsIdle <= 1'b1;
            if (octCnt_r == IDLE_HDR_LEN)
            begin
              txOctet  <= pay_r;
              octCnt_r <= 6'd1;
              idleSt_r <= IDLE_PAY;
            end
            else
            begin
              txOctet  <= hdr_r[octCnt_r[2:0]];
              octCnt_r <= octCnt_r + 6'd1;
            end
          end
        default:
          if (octetReq)
          begin
            if (octCnt_r == IDLE_PAY_LEN)
              idleSt_r <= IDLE_OFF;
            else
            begin
              txOctet       <= pay_r;
              txOctetIsIdle <= 1'b1;
              octCnt_r      <= octCnt_r + 6'd1;
            end
          end
      endcase
    end
  end
endmodule : ucp_device

// >>> design/ucp_pkg.sv
// ucp_pkg: constants shared by both ends of the cell port configuration link
package ucp_pkg;
  localparam logic [7:0] ADDR_IDLE_HDR1  = 8'h64;
  localparam logic [7:0] ADDR_IDLE_HDR2  = 8'h65;
  localparam logic [7:0] ADDR_IDLE_HDR3  = 8'h66;
  localparam logic [7:0] ADDR_IDLE_HDR4  = 8'h67;
  localparam logic [7:0] ADDR_IDLE_HDR5  = 8'h68;
  localparam logic [7:0] ADDR_IDLE_PAY   = 8'h69;
  localparam logic [7:0] ADDR_PORT_CFG   = 8'h6A;
  localparam logic [7:0] ADDR_RX_IRQ     = 8'h6B;
  localparam logic [7:0] RST_IDLE_HDR1   = 8'h00;
  localparam logic [7:0] RST_IDLE_HDR2   = 8'h00;
  localparam logic [7:0] RST_IDLE_HDR3   = 8'h00;
  localparam logic [7:0] RST_IDLE_HDR4   = 8'h01;
  localparam logic [7:0] RST_IDLE_HDR5   = 8'h52;
  localparam logic [7:0] RST_IDLE_PAY    = 8'h5A;
  localparam logic [7:0] RST_PORT_CFG    = 8'h10;
  localparam logic [7:0] RST_RX_IRQ      = 8'h00;
  // port configuration field positions
  localparam int CFG_HANDSHAKE = 5;
  localparam int CFG_MULTI     = 4;
  localparam int CFG_SHORT     = 3;
  localparam int CFG_DEPTH_HI  = 2;
  localparam int CFG_DEPTH_LO  = 1;
  localparam int CFG_WIDE      = 0;
  // rx interrupt register field positions
  localparam int IRQ_QRESET    = 6;
  localparam int IRQ_OVR_EN    = 5;
  localparam int IRQ_UND_EN    = 4;
  localparam int IRQ_RUNT_EN   = 3;
  localparam int IRQ_OVR_FLAG  = 2;
  localparam int IRQ_UND_FLAG  = 1;
  localparam int IRQ_RUNT_FLAG = 0;
  // cell lengths in octets
  localparam logic [5:0] CELL_LEN_NORMAL = 6'd53;
  localparam logic [5:0] CELL_LEN_WIDE   = 6'd54;
  localparam logic [5:0] CELL_LEN_SHORT  = 6'd52;
  localparam logic [5:0] IDLE_HDR_LEN    = 6'd5;
  localparam logic [5:0] IDLE_PAY_LEN    = 6'd48;
  // tx fifo working depth per code
  localparam logic [4:0] DEPTH_CODE0 = 5'd16;
  localparam logic [4:0] DEPTH_CODE1 = 5'd12;
  localparam logic [4:0] DEPTH_CODE2 = 5'd8;
  localparam logic [4:0] DEPTH_CODE3 = 5'd4;
  // link clock divider half period in core clocks
  localparam logic [3:0] LINK_HALF_DIV = 4'd6;
  localparam int SYNC_STAGES = 3;
endpackage : ucp_pkg

// >>> design/ucp_link_if.sv
// ucp_link_if: processor register port between host end and device end
`timescale 1ns/10ps
interface ucp_link_if;
  logic       linkClk;
  logic       wrStb;
  logic       rdStb;
  logic [7:0] addr;
  logic [7:0] wrData;
  logic [7:0] rdData;
  logic       rdValid;
  logic       irqReq;
  modport host   (output linkClk, output wrStb, output rdStb, output addr, output wrData,
                  input rdData, input rdValid, input irqReq);
  modport device (input linkClk, input wrStb, input rdStb, input addr, input wrData,
                  output rdData, output rdValid, output irqReq);
endinterface : ucp_link_if

// >>> design/ucp_host.sv
// ucp_host: processor-side end that makes the link clock and issues register accesses
`timescale 1ns/10ps
module ucp_host
  import ucp_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // user command port
  input  wire logic       cmdValid,
  input  wire logic       cmdWrite,
  input  wire logic [7:0] cmdAddr,
  input  wire logic [7:0] cmdData,
  output logic            cmdReady,
  output logic            respValid,
  output logic [7:0]      respData,
  output logic            irqSeen,
  // register link
  ucp_link_if.host        link
);
  import ucp_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_BUSY, H_WAIT} ucp_host_e;

  ////////////////////////////////////////////////////////////////////////////
  // link clock divider; a strobe spans a whole link period so the device sees one edge
  logic [3:0] div_r;
  logic       lowEnd;
  assign lowEnd = (div_r == LINK_HALF_DIV - 4'd1) & ~link.linkClk;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      div_r        <= 4'd0;
      link.linkClk <= 1'b0;
    end
    else if (div_r == LINK_HALF_DIV - 4'd1)
    begin
      div_r        <= 4'd0;
      link.linkClk <= ~link.linkClk;
    end
    else div_r <= div_r + 4'd1;
  end

  ////////////////////////////////////////////////////////////////////////////
  ucp_host_e st_r;
  logic      isRead_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r        <= H_IDLE;
      isRead_r    <= 1'b0;
      link.wrStb  <= 1'b0;
      link.rdStb  <= 1'b0;
      link.addr   <= 8'h00;
      link.wrData <= 8'h00;
      cmdReady    <= 1'b0;
      respValid   <= 1'b0;
      respData    <= 8'h00;
    end
    else
    begin
      respValid <= 1'b0;
      cmdReady  <= 1'b0;
      case (st_r)
        H_IDLE:
          if (cmdValid & lowEnd & ~cmdReady)
          begin
            link.addr   <= cmdAddr;
            link.wrData <= cmdData;
            link.wrStb  <= cmdWrite;
            link.rdStb  <= ~cmdWrite;
            isRead_r    <= ~cmdWrite;
            cmdReady    <= 1'b1;
            st_r        <= H_BUSY;
          end
        // the read answer arrives while the strobe still stands, so it is caught here
        H_BUSY:
          if (isRead_r & link.rdValid)
          begin
            respData  <= link.rdData;
            respValid <= 1'b1;
            st_r      <= H_WAIT;
          end
          else if (lowEnd)
          begin
            link.wrStb <= 1'b0;
            link.rdStb <= 1'b0;
            st_r       <= H_IDLE;
          end
        // answered; the strobe is kept up to the end of the link period
        default:
          if (lowEnd)
          begin
            link.wrStb <= 1'b0;
            link.rdStb <= 1'b0;
            st_r       <= H_IDLE;
          end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst) irqSeen <= 1'b0;
    else     irqSeen <= link.irqReq;
  end
endmodule : ucp_host

// >>> testbench/ucp_link_assertions.sv
// ucp_link_assertions: timing and content checks on the register link
`timescale 1ns/10ps
module ucp_link_assertions
  import ucp_pkg::*;
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // link
  input wire logic       linkClk,
  input wire logic       wrStb,
  input wire logic       rdStb,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdData,
  input wire logic       rdValid,
  input wire logic       irqReq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sequence s_clk_high;
    linkClk [*6];
  endsequence
  sequence s_clk_low;
    !linkClk [*6];
  endsequence
  sequence s_req_held;
    ($stable(addr) && $stable(wrData)) [*7];
  endsequence
  a_link_period: assert property ($rose(linkClk) |-> s_clk_high ##1 s_clk_low ##1 linkClk)
    else $error("link clock period wrong");
  a_request_held: assert property ($rose(wrStb || rdStb) |=> s_req_held)
    else $error("address or data moved under strobe");
  a_strobe_single: assert property (!(wrStb && rdStb))
    else $error("read and write strobes together");
  a_valid_pulse: assert property (rdValid |=> !rdValid)
    else $error("read valid longer than one cycle");
  a_valid_cause: assert property (rdValid |-> rdStb && !wrStb)
    else $error("read valid without read strobe");
  a_read_answered: assert property ($rose(rdStb) |-> ##[1:16] rdValid)
    else $error("read not answered");
  a_irq_fixed_bits: assert property (rdValid && addr == ADDR_RX_IRQ |-> !rdData[7] && !rdData[IRQ_UND_EN])
    else $error("fixed interrupt register bits set");
  a_cfg_unused: assert property (rdValid && addr == ADDR_PORT_CFG |-> rdData[7:6] == 2'b00)
    else $error("unused configuration bits set");
  a_irq_follows: assert property (rdValid && addr == ADDR_RX_IRQ && (rdData[5:3] & rdData[2:0]) != 3'b000
    |-> irqReq || $past(irqReq) || $past(irqReq, 2))
    else $error("enabled flag without interrupt");
  a_unmapped_zero: assert property (rdValid && (addr < ADDR_IDLE_HDR1 || addr > ADDR_RX_IRQ) |-> rdData == 8'h00)
    else $error("unmapped read not zero");
endmodule : ucp_link_assertions

// >>> testbench/utopia_cell_port_config_test.sv
// utopia_cell_port_config_test: both ends joined; registers, idle cells and events
`timescale 1ns/10ps
module utopia_cell_port_config_test;
  import ucp_pkg::*;
  // stimulus
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmdValid = 1'b0;
  logic        cmdWrite = 1'b0;
  logic [7:0]  cmdAddr = 8'h00;
  logic [7:0]  cmdData = 8'h00;
  logic        atmMode = 1'b1;
  logic        rxOverrunEvt = 1'b0;
  logic        rxUnderrunEvt = 1'b0;
  logic        rxShortCellEvt = 1'b0;
  logic        userCellAvail = 1'b0;
  logic        octetReq = 1'b0;
  // observed
  logic        cmdReady, respValid, irqSeen, txOctetIsIdle, rxQueueClear;
  logic        cellHandshake, multiPortSelect, wideBusSelect, hit;
  logic [7:0]  respData, txOctet, rdv, v;
  logic [5:0]  cellLength;
  logic [4:0]  txFifoDepth;
  int          miscompares = 0;
  int          checks = 0;
  int          clrCount = 0;
  // rows: write flag, address, data, expected read
  logic [24:0] rows [19] = '{25'h0640000, 25'h0650000, 25'h0660000, 25'h0670001, 25'h0680052,
    25'h069005A, 25'h06A0010, 25'h06B0000, 25'h0700000, 25'h16AFF00, 25'h06A003F, 25'h16B3800,
    25'h06B0028, 25'h170AA00, 25'h0700000, 25'h1683C00, 25'h068003C, 25'h169A500, 25'h06900A5};
  logic [7:0]  cfgs [6] = '{8'hFF, 8'h20, 8'h31, 8'h0A, 8'h0D, 8'h06};
  ////////////////////////////////////////
  ucp_link_if link ();
  ucp_host i_ucp_host (.core_clk, .rst, .cmdValid, .cmdWrite, .cmdAddr, .cmdData, .cmdReady, .respValid,
    .respData, .irqSeen, .link);
  ucp_device i_ucp_device (.core_clk, .rst, .link, .atmMode, .rxOverrunEvt, .rxUnderrunEvt, .rxShortCellEvt,
    .userCellAvail, .octetReq, .txOctet, .txOctetIsIdle, .cellHandshake, .multiPortSelect, .wideBusSelect,
    .cellLength, .txFifoDepth, .rxQueueClear);
  ucp_link_assertions i_ucp_link_assertions (.core_clk, .rst, .linkClk(link.linkClk), .wrStb(link.wrStb),
    .rdStb(link.rdStb), .addr(link.addr), .wrData(link.wrData), .rdData(link.rdData), .rdValid(link.rdValid),
    .irqReq(link.irqReq));
  always #5 core_clk = ~core_clk;
  // clear pulses counted, so a level instead of a pulse shows up as extra counts
  always @(negedge core_clk)
    if (rxQueueClear === 1'b1) clrCount++;
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdAddr = a;
    cmdData = d;
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (cmdReady !== 1'b1 && n < 100);
    cmdValid = 1'b0;
    while (!w && respValid !== 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    q = respData;
    if (n >= 100)
    begin
      chk(8'h00, 8'h01);
      summarize();
    end
    @(posedge core_clk);
    #1;
  endtask : acc
  task automatic cfgCase(input logic [7:0] c);
    acc(1'b1, ADDR_PORT_CFG, c, rdv);
    acc(1'b0, ADDR_PORT_CFG, 8'h00, rdv);
    chk(rdv, c & 8'h3F);
    chk(8'(cellLength), !atmMode ? 8'h35 : c[3] ? 8'h34 : c[0] ? 8'h36 : 8'h35);
    chk(8'(txFifoDepth), !atmMode ? 8'h10 : 8'h10 - 8'h04 * {6'h00, c[2:1]});
    chk({5'h00, cellHandshake, multiPortSelect, wideBusSelect},
        atmMode ? {5'h00, c[5] & !c[4], c[4], c[0]} : 8'h02);
  endtask : cfgCase
  task automatic octet;
    octetReq = 1'b1;
    @(posedge core_clk);
    #1;
    octetReq = 1'b0;
    hit = 1'b0;
    repeat (2)
    begin
      if (txOctetIsIdle === 1'b1 && !hit)
      begin
        hit = 1'b1;
        v = txOctet;
      end
      @(posedge core_clk);
      #1;
    end
  endtask : octet
  task automatic evt(input int k, input logic [7:0] en, input logic [7:0] fl, input logic irq);
    acc(1'b1, ADDR_RX_IRQ, en, rdv);
    {rxOverrunEvt, rxUnderrunEvt, rxShortCellEvt} = 3'(3'b100 >> k);
    @(posedge core_clk);
    #1;
    {rxOverrunEvt, rxUnderrunEvt, rxShortCellEvt} = 3'b000;
    // fixed wait, so an interrupt that must stay low has time to show
    repeat (4)
    begin
      @(posedge core_clk);
      #1;
    end
    chk({7'h00, irqSeen}, {7'h00, irq});
    acc(1'b0, ADDR_RX_IRQ, 8'h00, rdv);
    chk(rdv, en | fl);
    acc(1'b0, ADDR_RX_IRQ, 8'h00, rdv);
    chk(rdv, en);
    chk({7'h00, irqSeen}, 8'h00);
  endtask : evt
  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    foreach (rows[i])
    begin
      acc(rows[i][24], rows[i][23:16], rows[i][15:8], rdv);
      if (!rows[i][24]) chk(rdv, rows[i][7:0]);
    end
    foreach (cfgs[i]) cfgCase(cfgs[i]);
    atmMode = 1'b0;
    cfgCase(8'h2B);
    atmMode = 1'b1;
    // one whole idle cell and the request that closes it
    for (int i = 0; i < 54; i++)
    begin
      octet();
      chk({7'h00, hit}, {7'h00, i < 53});
      if (i < 53) chk(v, i < 4 ? {7'h00, i == 3} : i == 4 ? 8'h3C : 8'hA5);
    end
    userCellAvail = 1'b1;
    octet();
    chk({7'h00, hit}, 8'h00);
    userCellAvail = 1'b0;
    atmMode = 1'b0;
    octet();
    chk({7'h00, hit}, 8'h00);
    atmMode = 1'b1;
    // only a 0 to 1 change of the clear bit may pulse
    acc(1'b1, ADDR_RX_IRQ, 8'h40, rdv);
    acc(1'b1, ADDR_RX_IRQ, 8'h40, rdv);
    acc(1'b1, ADDR_RX_IRQ, 8'h00, rdv);
    acc(1'b1, ADDR_RX_IRQ, 8'h40, rdv);
    acc(1'b0, ADDR_RX_IRQ, 8'h00, rdv);
    chk(rdv, 8'h40);
    chk(8'(clrCount), 8'h02);
    evt(0, 8'h28, 8'h04, 1'b1);
    evt(1, 8'h28, 8'h02, 1'b0);
    evt(2, 8'h28, 8'h01, 1'b1);
    evt(0, 8'h08, 8'h04, 1'b0);
    evt(2, 8'h20, 8'h01, 1'b0);
    atmMode = 1'b0;
    evt(0, 8'h20, 8'h00, 1'b0);
    atmMode = 1'b1;
    acc(1'b1, ADDR_PORT_CFG, 8'h2B, rdv);
    acc(1'b0, ADDR_PORT_CFG, 8'h00, rdv);
    chk(rdv, 8'h2B);
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk({5'h00, cellHandshake, multiPortSelect, wideBusSelect}, 8'h02);
    chk(8'(cellLength), 8'h35);
    acc(1'b0, ADDR_PORT_CFG, 8'h00, rdv);
    chk(rdv, 8'h10);
    acc(1'b0, ADDR_IDLE_HDR5, 8'h00, rdv);
    chk(rdv, 8'h52);
    summarize();
  end
endmodule : utopia_cell_port_config_test
